// file: prm_pkg.sv
// Package for the peripheral pin route unit: offsets, fields, resets, carriers
package prm_pkg;

    // Register offsets
    localparam logic [1:0] PRM_LOGIC_EVENT_OFS = 2'h0;
    localparam logic [1:0] PRM_SERIAL_PINS_OFS = 2'h1;
    localparam logic [1:0] PRM_TIMER_A_OFS     = 2'h2;
    localparam logic [1:0] PRM_TIMER_B_OFS     = 2'h3;

    // Field positions, logic/event register
    localparam int PRM_EVENT_PIN_ZERO_BIT  = 0;
    localparam int PRM_EVENT_PIN_ONE_BIT   = 1;
    localparam int PRM_EVENT_PIN_TWO_BIT   = 2;
    localparam int PRM_LOGIC_TABLE_ZERO_BIT = 4;
    localparam int PRM_LOGIC_TABLE_ONE_BIT  = 5;
    // Field positions, serial register
    localparam int PRM_UART_ALT_BIT        = 0;
    localparam int PRM_SYNC_SERIAL_ALT_BIT = 2;
    // Field positions, timer registers
    localparam int PRM_TIMER_A_WAVE_LSB    = 0;
    localparam int PRM_TIMER_A_SPLIT_LSB   = 3;
    localparam int PRM_TIMER_B_ALT_BIT     = 0;

    // Writable bit masks (unimplemented bits read zero)
    localparam logic [7:0] PRM_LOGIC_EVENT_MASK = 8'h37;
    localparam logic [7:0] PRM_SERIAL_PINS_MASK = 8'h05;
    localparam logic [7:0] PRM_TIMER_A_MASK     = 8'h3F;
    localparam logic [7:0] PRM_TIMER_B_MASK     = 8'h01;

    // Reset values
    localparam logic [7:0] PRM_CTRL_RESET = 8'h00;

    // Number of timer A waveform outputs
    localparam int PRM_TIMER_A_WAVES = 6;

    // Register bus request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } prm_bus_req_t;

    // Peripheral signals entering the router
    typedef struct packed {
        logic       logic_table_zero;
        logic       logic_table_one;
        logic [2:0] event_out;
        logic [3:0] sync_serial;
        logic [2:0] uart;
        logic [5:0] timer_a_wave;
        logic       timer_b_out;
    } prm_periph_t;

    // Pin-side drive: value only, per default and alternative position; event pins have one position
    typedef struct packed {
        logic [1:0] logic_table_zero;
        logic [1:0] logic_table_one;
        logic [2:0] event_pin;
        logic [7:0] sync_serial;
        logic [5:0] uart;
        logic [11:0] timer_a_wave;
        logic [1:0] timer_b_out;
    } prm_pins_t;

endpackage

// file: prm_route_sel.sv
// Steers one signal to its default or alternative pin position
module prm_route_sel
    import prm_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic [W-1:0] sig,
    input  wire logic         alt,
    output logic [W-1:0]      dflt_val,
    output logic [W-1:0]      alt_val,
    output logic              dflt_en,
    output logic              alt_en
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bit clear picks default, bit set picks alternative
    always_comb begin
        dflt_en  = ~alt;
        alt_en   = alt;
        dflt_val = alt ? '0 : sig;
        alt_val  = alt ? sig : '0;
    end

endmodule

// file: prm_pin_route_unit.sv
// Peripheral pin route unit: four control registers and the signal router
//
// Behaviour
// - Each routed signal except event outputs and, in normal mode, timer A outputs 5..3 goes to its default pin while its bit is 0 and alternative when 1.
// - Bit 5 of the logic/event register moves logic table 1 output to its alternative pin.
// - Bit 4 of the logic/event register moves logic table 0 output to its alternative pin.
// - Bits 2..0 of the logic/event register enable event outputs 2..0; cleared disables.
// - Bit 2 of the serial register moves all sync serial pins to the alternative set.
// - Bit 0 of the serial register moves all uart pins to the alternative set.
// - Bits 5..3 of the timer A register move waveform outputs 5..3 only in split mode.
// - In normal timer A mode bits 5..3 of the timer A register do not affect routing.
// - Bits 2..0 of the timer A register move waveform outputs 2..0 to alternative pins.
// - In split mode bits 2..0 route low-byte compare channels 2..0 respectively.
// - Bit 0 of the timer B register moves the timer B output to its alternative pin.
module prm_pin_route_unit
    import prm_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire prm_bus_req_t bus,
    input  wire logic         timer_a_split,
    input  wire prm_periph_t  periph,
    output logic [7:0]        rdata,
    output prm_pins_t         pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] logic_event;
        logic [7:0] serial_pins;
        logic [7:0] timer_a;
        logic [7:0] timer_b;
        logic [7:0] rdata;
        prm_pins_t  pins;
    } prm_state_t;

    prm_state_t st_r;
    prm_state_t st_nxt;
    prm_pins_t  route;

    logic [5:0] ta_alt;
    logic [1:0] lt0_v;
    logic [1:0] lt1_v;
    logic [1:0] tb_v;
    logic [3:0] ss_d;
    logic [3:0] ss_a;
    logic [2:0] ua_d;
    logic [2:0] ua_a;
    logic [5:0] ta_d;
    logic [5:0] ta_a;

    // Mask of implemented bits at an offset
    function automatic logic [7:0] prm_mask(input logic [1:0] ofs);
        if (ofs == PRM_LOGIC_EVENT_OFS) begin
            return PRM_LOGIC_EVENT_MASK;
        end else if (ofs == PRM_SERIAL_PINS_OFS) begin
            return PRM_SERIAL_PINS_MASK;
        end else if (ofs == PRM_TIMER_A_OFS) begin
            return PRM_TIMER_A_MASK;
        end else begin
            return PRM_TIMER_B_MASK;
        end
    endfunction

    // Timer A alternative selects; upper three only in split mode
    always_comb begin
        ta_alt[2:0] = st_r.timer_a[PRM_TIMER_A_WAVE_LSB +: 3];
        ta_alt[5:3] = timer_a_split ? st_r.timer_a[PRM_TIMER_A_SPLIT_LSB +: 3]
                                    : 3'h0;
    end

    // Logic table outputs
    prm_route_sel #(.W(1)) u_lt0 (
        .sig      (periph.logic_table_zero),
        .alt      (st_r.logic_event[PRM_LOGIC_TABLE_ZERO_BIT]),
        .dflt_val (lt0_v[0]),
        .alt_val  (lt0_v[1]),
        .dflt_en  (),
        .alt_en   ()
    );
    prm_route_sel #(.W(1)) u_lt1 (
        .sig      (periph.logic_table_one),
        .alt      (st_r.logic_event[PRM_LOGIC_TABLE_ONE_BIT]),
        .dflt_val (lt1_v[0]),
        .alt_val  (lt1_v[1]),
        .dflt_en  (),
        .alt_en   ()
    );

    // Serial pin groups move as a whole
    prm_route_sel #(.W(4)) u_ss (
        .sig      (periph.sync_serial),
        .alt      (st_r.serial_pins[PRM_SYNC_SERIAL_ALT_BIT]),
        .dflt_val (ss_d),
        .alt_val  (ss_a),
        .dflt_en  (),
        .alt_en   ()
    );
    prm_route_sel #(.W(3)) u_ua (
        .sig      (periph.uart),
        .alt      (st_r.serial_pins[PRM_UART_ALT_BIT]),
        .dflt_val (ua_d),
        .alt_val  (ua_a),
        .dflt_en  (),
        .alt_en   ()
    );

    // Timer A waveform outputs, one selector each
    for (genvar i = 0; i < PRM_TIMER_A_WAVES; i++) begin : g_ta
        prm_route_sel #(.W(1)) u_ta (
            .sig      (periph.timer_a_wave[i]),
            .alt      (ta_alt[i]),
            .dflt_val (ta_d[i]),
            .alt_val  (ta_a[i]),
            .dflt_en  (),
            .alt_en   ()
        );
    end

    // Timer B output
    prm_route_sel #(.W(1)) u_tb (
        .sig      (periph.timer_b_out),
        .alt      (st_r.timer_b[PRM_TIMER_B_ALT_BIT]),
        .dflt_val (tb_v[0]),
        .alt_val  (tb_v[1]),
        .dflt_en  (),
        .alt_en   ()
    );

    // Gather pin drive; event pins gated by their enables
    always_comb begin
        route.logic_table_zero = lt0_v;
        route.logic_table_one  = lt1_v;
        route.event_pin        = periph.event_out
                               & st_r.logic_event[PRM_EVENT_PIN_ZERO_BIT +: 3];
        route.sync_serial      = {ss_a, ss_d};
        route.uart             = {ua_a, ua_d};
        route.timer_a_wave     = {ta_a, ta_d};
        route.timer_b_out      = tb_v;
    end

    // Register writes, read data and registered pin drive
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = 8'h00;
        st_nxt.pins  = route;
        if (bus.wr) begin
            if (bus.addr == PRM_LOGIC_EVENT_OFS) begin
                st_nxt.logic_event = bus.wdata & PRM_LOGIC_EVENT_MASK;
            end else if (bus.addr == PRM_SERIAL_PINS_OFS) begin
                st_nxt.serial_pins = bus.wdata & PRM_SERIAL_PINS_MASK;
            end else if (bus.addr == PRM_TIMER_A_OFS) begin
                st_nxt.timer_a = bus.wdata & PRM_TIMER_A_MASK;
            end else begin
                st_nxt.timer_b = bus.wdata & PRM_TIMER_B_MASK;
            end
        end
        if (bus.rd) begin
            if (bus.addr == PRM_LOGIC_EVENT_OFS) begin
                st_nxt.rdata = st_r.logic_event;
            end else if (bus.addr == PRM_SERIAL_PINS_OFS) begin
                st_nxt.rdata = st_r.serial_pins;
            end else if (bus.addr == PRM_TIMER_A_OFS) begin
                st_nxt.rdata = st_r.timer_a;
            end else begin
                st_nxt.rdata = st_r.timer_b;
            end
            st_nxt.rdata = st_nxt.rdata & prm_mask(bus.addr);
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign pins  = st_r.pins;

endmodule

// file: prm_pin_route_unit_asserts.sv
// Port checker for the pin route unit
module prm_pin_route_unit_asserts
    import prm_pkg::*;
(
    input wire logic         clk,
    input wire logic         rstn,
    input wire prm_bus_req_t bus,
    input wire logic         timer_a_split,
    input wire prm_periph_t  periph,
    input wire logic [7:0]   rdata,
    input wire prm_pins_t    pins
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Writable bits of one offset
    function automatic logic [7:0] msk(logic [1:0] a);
        return a == 2'h0 ? PRM_LOGIC_EVENT_MASK : a == 2'h1 ? PRM_SERIAL_PINS_MASK :
               a == 2'h2 ? PRM_TIMER_A_MASK : PRM_TIMER_B_MASK;
    endfunction
    // Register side
    property p_rd_mask;
        bus.rd |=> (rdata & ~msk($past(bus.addr))) == 8'h00;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("unused bits read set");
    property p_wr_rd;
        bus.wr ##1 (bus.rd && bus.addr == $past(bus.addr))
            |=> rdata == ($past(bus.wdata, 2) & msk($past(bus.addr)));
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("read after write differs");
    // Routing side
    property p_tb;
        $past(rstn) |-> pins.timer_b_out != 2'b11
            && (|pins.timer_b_out) == $past(periph.timer_b_out);
    endproperty
    a_tb: assert property (p_tb) else $error("timer b drive wrong");
    property p_lt;
        $past(rstn) |-> pins.logic_table_zero != 2'b11
            && (|pins.logic_table_zero) == $past(periph.logic_table_zero);
    endproperty
    a_lt: assert property (p_lt) else $error("logic table drive wrong");
    property p_ev;
        $past(rstn) |-> (pins.event_pin & ~$past(periph.event_out)) == 3'h0;
    endproperty
    a_ev: assert property (p_ev) else $error("event pin without event");
    property p_uart;
        $past(rstn) |-> !((|pins.uart[5:3]) && (|pins.uart[2:0]))
            && (pins.uart[5:3] | pins.uart[2:0]) == $past(periph.uart);
    endproperty
    a_uart: assert property (p_uart) else $error("uart pins split");
    property p_norm;
        $past(rstn) && !$past(timer_a_split) |-> pins.timer_a_wave[11:9] == 3'h0;
    endproperty
    a_norm: assert property (p_norm) else $error("upper waves moved in normal mode");
    property p_wave;
        $past(rstn) |-> (pins.timer_a_wave[11:6] | pins.timer_a_wave[5:0])
            == $past(periph.timer_a_wave);
    endproperty
    a_wave: assert property (p_wave) else $error("wave output lost");
endmodule

// file: prm_periph_model.sv
// Peripheral signal source that changes every cycle
module prm_periph_model
    import prm_pkg::*;
(
    input wire logic    clk,
    input wire logic    rstn,
    output prm_periph_t periph
);
    timeunit 1ns;
    timeprecision 1ns;
    // Shift register with inverted feedback
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            periph <= '0;
        end else begin
            periph <= {periph[17:0], ~(periph[18] ^ periph[4])};
        end
    end
endmodule

// file: prm_pin_route_unit_bench.sv
// Bench for the pin route unit
`define CMP(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module prm_pin_route_unit_bench
    import prm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk, rstn, split;
    prm_bus_req_t bus;
    prm_periph_t  periph, p;
    prm_pins_t    pins;
    logic [7:0]   rdata;
    logic [7:0]   sh [4];
    int           errors, checked, cyc;
    prm_pin_route_unit i_prm_pin_route_unit (.clk(clk), .rstn(rstn), .bus(bus),
        .timer_a_split(split), .periph(periph), .rdata(rdata), .pins(pins));
    prm_periph_model i_prm_periph_model (.clk(clk), .rstn(rstn), .periph(periph));
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            end_sim();
        end
    end
    function automatic logic [7:0] msk(logic [1:0] a);
        return a == PRM_LOGIC_EVENT_OFS ? PRM_LOGIC_EVENT_MASK :
               a == PRM_SERIAL_PINS_OFS ? PRM_SERIAL_PINS_MASK :
               a == PRM_TIMER_A_OFS ? PRM_TIMER_A_MASK : PRM_TIMER_B_MASK;
    endfunction
    // Expected drive from shadow registers and one input sample
    function automatic prm_pins_t route(prm_periph_t v, logic s);
        prm_pins_t  e;
        logic [5:0] a;
        e.logic_table_zero = sh[0][4] ? {v.logic_table_zero, 1'b0} : {1'b0, v.logic_table_zero};
        e.logic_table_one = sh[0][5] ? {v.logic_table_one, 1'b0} : {1'b0, v.logic_table_one};
        e.event_pin = v.event_out & sh[0][2:0];
        e.sync_serial = sh[1][2] ? {v.sync_serial, 4'h0} : {4'h0, v.sync_serial};
        e.uart = sh[1][0] ? {v.uart, 3'h0} : {3'h0, v.uart};
        a = {sh[2][5:3] & {3{s}}, sh[2][2:0]};
        e.timer_a_wave = {v.timer_a_wave & a, v.timer_a_wave & ~a};
        e.timer_b_out = sh[3][0] ? {v.timer_b_out, 1'b0} : {1'b0, v.timer_b_out};
        return e;
    endfunction
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        sh[a] = d & msk(a);
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(logic [1:0] a, logic [7:0] x);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        `CMP("rdata", x, rdata)
        @(negedge clk);
        `CMP("rdata idle", 8'h00, rdata)
    endtask
    task automatic chk(int n);
        repeat (2) @(negedge clk);
        p = periph;
        repeat (n) begin
            @(negedge clk);
            `CMP("pins", route(p, split), pins)
            p = periph;
        end
    endtask
    task automatic t_reset();
        for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
        chk(4);
    endtask
    // Write all ones then read at once, back to back
    task automatic t_masks();
        for (int a = 0; a < 4; a++) begin
            @(posedge clk);
            bus <= '{a[1:0], 8'hFF, 1'b1, 1'b0};
            @(posedge clk);
            bus <= '{a[1:0], 8'h00, 1'b0, 1'b1};
            @(posedge clk);
            bus.rd <= 1'b0;
            @(negedge clk);
            `CMP("mask", msk(a[1:0]), rdata)
            wr(a[1:0], 8'h00);
        end
    endtask
    task automatic t_logic();
        wr(2'h0, 8'h07);
        chk(6);
        wr(2'h0, 8'h10);
        chk(6);
        wr(2'h0, 8'hEF);
        chk(6);
    endtask
    task automatic t_serial();
        wr(2'h1, 8'h04);
        chk(6);
        wr(2'h1, 8'hFB);
        chk(6);
    endtask
    task automatic t_timer();
        wr(2'h2, 8'h38);
        chk(6);
        @(posedge clk);
        split <= 1'b1;
        chk(6);
        wr(2'h2, 8'h07);
        chk(6);
        @(posedge clk);
        split <= 1'b0;
        chk(6);
        wr(2'h3, 8'hFF);
        chk(6);
        rd(2'h3, 8'h01);
    endtask
    // Load every register, reset in mid-run, then expect reset state again
    task automatic t_mid_reset();
        wr(2'h0, 8'h37);
        wr(2'h1, 8'h05);
        wr(2'h2, 8'h3F);
        wr(2'h3, 8'h01);
        @(posedge clk);
        rstn <= 1'b0;
        sh = '{default: 8'h00};
        repeat (2) @(negedge clk);
        `CMP("pins in reset", '0, pins)
        `CMP("rdata in reset", 8'h00, rdata)
        @(posedge clk);
        rstn <= 1'b1;
        t_reset();
    endtask
    task automatic end_sim();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Reset, then scenarios
    initial begin
        cyc = 0;
        errors = 0;
        checked = 0;
        rstn = 1'b0;
        split = 1'b0;
        bus = '0;
        sh = '{default: 8'h00};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_masks();
        t_logic();
        t_serial();
        t_timer();
        t_mid_reset();
        end_sim();
    end
endmodule
bind prm_pin_route_unit prm_pin_route_unit_asserts i_prm_pin_route_unit_asserts (.clk(clk),
    .rstn(rstn), .bus(bus), .timer_a_split(timer_a_split), .periph(periph),
    .rdata(rdata), .pins(pins));
